//--- include/dbgtt_pkg.sv
// Constants, field layouts and carrier types of the debug trigger and trace unit.
// Assumes one bus clock shared by the CPU, the register port and this unit.
package dbgtt_pkg;

  // Register indices on the 4-bit register port
  localparam logic [3:0] DBGTT_REG_CMPA_HI = 4'h0;
  localparam logic [3:0] DBGTT_REG_CMPA_LO = 4'h1;
  localparam logic [3:0] DBGTT_REG_CMPB_HI = 4'h2;
  localparam logic [3:0] DBGTT_REG_CMPB_LO = 4'h3;
  localparam logic [3:0] DBGTT_REG_FIFO_HI = 4'h4;
  localparam logic [3:0] DBGTT_REG_FIFO_LO = 4'h5;
  localparam logic [3:0] DBGTT_REG_CTRL = 4'h6;
  localparam logic [3:0] DBGTT_REG_TRIG = 4'h7;
  localparam logic [3:0] DBGTT_REG_STAT = 4'h8;

  // Control register fields
  localparam int DBGTT_CTRL_ENABLE = 7;
  localparam int DBGTT_CTRL_ARM = 6;
  localparam int DBGTT_CTRL_TAG = 5;
  localparam int DBGTT_CTRL_BRKEN = 4;
  localparam int DBGTT_CTRL_RWA = 3;
  localparam int DBGTT_CTRL_RW_QUALIFY_A_ENABLE = 2;
  localparam int DBGTT_CTRL_RWB = 1;
  localparam int DBGTT_CTRL_RWBEN = 0;

  // Trigger register fields
  localparam int DBGTT_TRIG_SEL = 7;
  localparam int DBGTT_TRIG_BEGIN = 6;
  localparam int DBGTT_TRIG_MODE_LSB = 0;

  // Status register fields
  localparam int DBGTT_STAT_RUN_ARMED_FLAG = 7;
  localparam int DBGTT_STAT_AF = 6;
  localparam int DBGTT_STAT_BF = 5;
  localparam int DBGTT_STAT_CNT_LSB = 0;

  // Trigger modes
  localparam logic [3:0] DBGTT_MODE_A_ONLY = 4'h0;
  localparam logic [3:0] DBGTT_MODE_A_OR_B = 4'h1;
  localparam logic [3:0] DBGTT_MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] DBGTT_MODE_EVENT_B = 4'h3;
  localparam logic [3:0] DBGTT_MODE_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] DBGTT_MODE_A_AND_B_DATA = 4'h5;
  localparam logic [3:0] DBGTT_MODE_A_AND_NOT_B_DATA = 4'h6;
  localparam logic [3:0] DBGTT_MODE_INSIDE = 4'h7;
  localparam logic [3:0] DBGTT_MODE_OUTSIDE = 4'h8;

  // Sizes and timing
  localparam int DBGTT_DEPTH = 8;
  localparam int DBGTT_QDEPTH = 3;
  localparam logic [3:0] DBGTT_FULL_CNT = 4'h8;
  localparam logic [1:0] DBGTT_SKIP_BUS_CYCLES = 2'h2;

  // Reset values
  localparam logic [7:0] DBGTT_RST_BYTE = 8'h00;
  localparam logic [15:0] DBGTT_RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    DBGTT_COF_COND_TAKEN = 2'h0,
    DBGTT_COF_BRA_BRN = 2'h1,
    DBGTT_COF_INDIRECT = 2'h2,
    DBGTT_COF_DEST = 2'h3
  } dbgtt_cof_kind_t;

  typedef struct packed {
    logic valid;
    dbgtt_cof_kind_t kind;
    logic [15:0] op_addr;
    logic [15:0] dest_addr;
    logic [15:0] hx;
  } dbgtt_cof_t;

  typedef struct packed {
    logic valid;
    logic rw;
    logic opfetch;
    logic bdc;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } dbgtt_bus_t;

  typedef enum logic [2:0] {
    DBGTT_ST_IDLE = 3'b001,
    DBGTT_ST_PRE = 3'b010,
    DBGTT_ST_STORE = 3'b100
  } dbgtt_state_t;

endpackage : dbgtt_pkg

//--- core/dbgtt_top.sv
// Debug trigger and trace unit: comparators, opcode trackers, trace FIFO, break requests.
// Assumes CPU bus, change-of-flow and queue signals are on CLK_I; register port same clock.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Two 16-bit comparators, optional R/W qualify each
// - Opcode tracking triggers only on executed opcodes
// - Comparators support inside and outside ranges
// - Background controller accesses never cause matches
// - A compares address; B address or data
// - Data compare uses write bus if write-qualified
// - Match breaks, stores data, begins or ends trace
// - Eight-entry FIFO read in stored order
// - Status reports FIFO valid word count
// - Reading FIFO low byte shifts the FIFO
// - Event modes store data byte, high unused
// - Begin trace skips trigger and next two bus cycles' flow
// - End trace keeps trigger flow entry last
// - Disarmed low-byte read pushes last opcode address
// - Taken conditional branch stores opcode address
// - Indirect jump or call stores index address
// - Interrupt and returns store destination address
// - Tag request marks fetched opcode
// - Force request held until CPU break acknowledge
// - Separate opcode tracker per comparator
// - Arm write sets armed, clears flags, count
// - Runs end on full, trigger, or disarm
module dbgtt_top
  import dbgtt_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire dbgtt_pkg::dbgtt_bus_t CPU_BUS_I,
  input wire dbgtt_pkg::dbgtt_cof_t CPU_COF_I,
  input wire logic CPU_OP_EXEC_I,
  input wire logic CPU_Q_FLUSH_I,
  input wire logic CPU_BRK_ACK_I,
  output logic BRK_TAG_O,
  output logic BRK_FORCE_O
);
  import dbgtt_pkg::*;

  logic [15:0] cmpa_reg, cmpb_reg;
  logic [7:0] ctrl_reg, trig_reg, rdata_reg;
  logic af_reg, bf_reg, a_seen_reg, force_reg;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] skip_reg;
  logic [15:0] last_fetch_reg;
  logic [15:0] fifo_reg [DBGTT_DEPTH];
  dbgtt_state_t st_reg, st_next;

  // Register port decode
  logic wr_ctrl, rd_lo, start_run, stop_run;
  assign wr_ctrl = REG_WR_I && (REG_ADDR_I == DBGTT_REG_CTRL);
  assign rd_lo = REG_RD_I && (REG_ADDR_I == DBGTT_REG_FIFO_LO);
  assign start_run = wr_ctrl && REG_WDATA_I[DBGTT_CTRL_ARM] && REG_WDATA_I[DBGTT_CTRL_ENABLE];
  assign stop_run = wr_ctrl && !start_run;

  logic [3:0] mode;
  logic is_event, begin_type, armed;
  assign mode = trig_reg[DBGTT_TRIG_MODE_LSB +: 4];
  assign is_event = (mode == DBGTT_MODE_EVENT_B) || (mode == DBGTT_MODE_A_THEN_EVENT_B);
  // Event-only runs are always begin type
  assign begin_type = trig_reg[DBGTT_TRIG_BEGIN] || is_event;
  assign armed = (st_reg != DBGTT_ST_IDLE);

  // Comparators
  logic live, qa, qb, a_eq, b_eq, a_lt, b_gt, d_eq;
  logic [7:0] data_sel;
  assign live = CPU_BUS_I.valid && !CPU_BUS_I.bdc && ctrl_reg[DBGTT_CTRL_ENABLE];
  assign qa = !ctrl_reg[DBGTT_CTRL_RW_QUALIFY_A_ENABLE] || (CPU_BUS_I.rw == ctrl_reg[DBGTT_CTRL_RWA]);
  assign qb = !ctrl_reg[DBGTT_CTRL_RWBEN] || (CPU_BUS_I.rw == ctrl_reg[DBGTT_CTRL_RWB]);
  assign data_sel = (ctrl_reg[DBGTT_CTRL_RW_QUALIFY_A_ENABLE] && !ctrl_reg[DBGTT_CTRL_RWA]) ?
                    CPU_BUS_I.wdata : CPU_BUS_I.rdata;
  assign a_eq = (CPU_BUS_I.addr == cmpa_reg);
  assign b_eq = (CPU_BUS_I.addr == cmpb_reg);
  assign a_lt = (CPU_BUS_I.addr < cmpa_reg);
  assign b_gt = (CPU_BUS_I.addr > cmpb_reg);
  assign d_eq = (data_sel == cmpb_reg[7:0]);

  // Channel conditions; range and full modes fold everything into channel A
  logic [1:0] chan_raw, chan_trk, chan_q;
  logic tag_cond;
  always_comb begin
    chan_raw = 2'b00;
    unique case (mode)
      DBGTT_MODE_A_AND_B_DATA: chan_raw[0] = a_eq && qa && d_eq;
      DBGTT_MODE_A_AND_NOT_B_DATA: chan_raw[0] = a_eq && qa && !d_eq;
      DBGTT_MODE_INSIDE: chan_raw[0] = !a_lt && !b_gt && qa;
      DBGTT_MODE_OUTSIDE: chan_raw[0] = (a_lt || b_gt) && qa;
      default: begin
        chan_raw[0] = a_eq && qa;
        chan_raw[1] = b_eq && qb;
      end
    endcase
    if (!live) begin
      chan_raw = 2'b00;
    end
  end

  // Opcode trackers mirror the instruction queue, one per comparator
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_trk
      logic [DBGTT_QDEPTH-1:0] tq_reg, tq_next;
      logic [1:0] tn_reg, tn_next;
      logic push, pop;
      assign push = CPU_BUS_I.valid && CPU_BUS_I.opfetch && (tn_reg < 2'(DBGTT_QDEPTH) || pop);
      assign pop = CPU_OP_EXEC_I && (tn_reg != 2'h0);
      always_comb begin
        tq_next = tq_reg;
        tn_next = tn_reg;
        if (pop) begin
          tq_next = tq_reg >> 1;
          tn_next = tn_reg - 2'h1;
        end
        if (push) begin
          tq_next[tn_next] = chan_raw[g];
          tn_next = tn_next + 2'h1;
        end
      end
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          tq_reg <= '0;
          tn_reg <= 2'h0;
        end else if (CPU_Q_FLUSH_I) begin
          tq_reg <= '0;
          tn_reg <= 2'h0;
        end else begin
          tq_reg <= tq_next;
          tn_reg <= tn_next;
        end
      end
      assign chan_trk[g] = pop && tq_reg[0] && ctrl_reg[DBGTT_CTRL_ENABLE];
    end
  endgenerate

  assign chan_q = trig_reg[DBGTT_TRIG_SEL] ? chan_trk : chan_raw;

  // Trigger combination; the untracked copy feeds tag requests at fetch time
  logic trig, trig_raw;
  always_comb begin
    unique case (mode)
      DBGTT_MODE_A_OR_B: begin
        trig = chan_q[0] || chan_q[1];
        trig_raw = chan_raw[0] || chan_raw[1];
      end
      DBGTT_MODE_A_THEN_B,
      DBGTT_MODE_A_THEN_EVENT_B: begin
        trig = a_seen_reg && chan_q[1];
        trig_raw = a_seen_reg && chan_raw[1];
      end
      DBGTT_MODE_EVENT_B: begin
        trig = chan_q[1];
        trig_raw = chan_raw[1];
      end
      default: begin
        trig = chan_q[0];
        trig_raw = chan_raw[0];
      end
    endcase
  end
  // Full modes ignore the data match for tag requests
  assign tag_cond = ((mode == DBGTT_MODE_A_AND_B_DATA) || (mode == DBGTT_MODE_A_AND_NOT_B_DATA)) ?
                    (a_eq && qa && live) : trig_raw;

  // Change-of-flow address selection
  logic cof_ok;
  logic [15:0] cof_addr;
  always_comb begin
    cof_ok = CPU_COF_I.valid;
    unique case (CPU_COF_I.kind)
      DBGTT_COF_COND_TAKEN: cof_addr = CPU_COF_I.op_addr;
      DBGTT_COF_INDIRECT: cof_addr = CPU_COF_I.hx;
      DBGTT_COF_DEST: cof_addr = CPU_COF_I.dest_addr;
      DBGTT_COF_BRA_BRN: begin
        cof_addr = DBGTT_RST_WORD;
        cof_ok = 1'b0;
      end
    endcase
  end

  // Storage decision and run sequencing
  logic store, prof_push, push, shift;
  logic [15:0] push_data;
  always_comb begin
    st_next = st_reg;
    store = 1'b0;
    push_data = cof_addr;
    unique case (st_reg)
      DBGTT_ST_IDLE: ;
      DBGTT_ST_PRE: begin
        if (is_event) begin
          store = trig;
          push_data = {8'h00, data_sel};
        end else if (begin_type) begin
          if (trig) begin
            st_next = DBGTT_ST_STORE;
          end
        end else begin
          store = cof_ok;
          if (trig) begin
            st_next = DBGTT_ST_IDLE;
          end
        end
      end
      DBGTT_ST_STORE: store = cof_ok && (skip_reg == 2'h0);
      default: st_next = DBGTT_ST_IDLE;
    endcase
    if (begin_type && store && (cnt_reg == DBGTT_FULL_CNT - 4'h1)) begin
      st_next = DBGTT_ST_IDLE;
    end
    if (stop_run) begin
      st_next = DBGTT_ST_IDLE;
    end
    if (start_run) begin
      st_next = DBGTT_ST_PRE;
    end
  end

  assign prof_push = rd_lo && !armed;
  assign push = store || prof_push;
  assign shift = push || rd_lo;

  always_comb begin
    cnt_next = cnt_reg;
    if (start_run) begin
      cnt_next = 4'h0;
    end else if (push) begin
      if (cnt_reg != DBGTT_FULL_CNT) begin
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (rd_lo && (cnt_reg != 4'h0)) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= DBGTT_ST_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // Pipeline blanking after a begin trigger counts bus cycles
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      skip_reg <= 2'h0;
    end else if (st_reg == DBGTT_ST_PRE && st_next == DBGTT_ST_STORE) begin
      skip_reg <= DBGTT_SKIP_BUS_CYCLES;
    end else if (CPU_BUS_I.valid && skip_reg != 2'h0) begin
      skip_reg <= skip_reg - 2'h1;
    end
  end

  // Trace FIFO: enters at 0, leaves at the top; oldest is dropped when full
  generate
    for (g = 0; g < DBGTT_DEPTH; g++) begin : g_fifo
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          fifo_reg[g] <= DBGTT_RST_WORD;
        end else if (shift) begin
          if (g == 0) begin
            fifo_reg[g] <= push ? (store ? push_data : last_fetch_reg) : DBGTT_RST_WORD;
          end else begin
            fifo_reg[g] <= fifo_reg[g-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      last_fetch_reg <= DBGTT_RST_WORD;
    end else if (CPU_BUS_I.valid && CPU_BUS_I.opfetch && !CPU_BUS_I.bdc) begin
      last_fetch_reg <= CPU_BUS_I.addr;
    end
  end

  // Match flags and sequence latch; hardware set beats the arm clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      af_reg <= 1'b0;
      bf_reg <= 1'b0;
      a_seen_reg <= 1'b0;
    end else begin
      af_reg <= (armed && chan_q[0]) || (af_reg && !start_run);
      bf_reg <= (armed && chan_q[1]) || (bf_reg && !start_run);
      a_seen_reg <= (armed && chan_q[0]) || (a_seen_reg && !start_run);
    end
  end

  // Break requests
  logic brk_en;
  assign brk_en = armed && ctrl_reg[DBGTT_CTRL_BRKEN];
  assign BRK_TAG_O = brk_en && ctrl_reg[DBGTT_CTRL_TAG] && CPU_BUS_I.opfetch && tag_cond;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      force_reg <= 1'b0;
    end else begin
      force_reg <= (brk_en && !ctrl_reg[DBGTT_CTRL_TAG] && trig) ||
                   (force_reg && !CPU_BRK_ACK_I);
    end
  end
  assign BRK_FORCE_O = force_reg;

  // Register writes
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmpa_reg <= DBGTT_RST_WORD;
      cmpb_reg <= DBGTT_RST_WORD;
      ctrl_reg <= DBGTT_RST_BYTE;
      trig_reg <= DBGTT_RST_BYTE;
    end else if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        DBGTT_REG_CMPA_HI: cmpa_reg[15:8] <= REG_WDATA_I;
        DBGTT_REG_CMPA_LO: cmpa_reg[7:0] <= REG_WDATA_I;
        DBGTT_REG_CMPB_HI: cmpb_reg[15:8] <= REG_WDATA_I;
        DBGTT_REG_CMPB_LO: cmpb_reg[7:0] <= REG_WDATA_I;
        DBGTT_REG_CTRL: ctrl_reg <= REG_WDATA_I;
        DBGTT_REG_TRIG: trig_reg <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    unique case (REG_ADDR_I)
      DBGTT_REG_CMPA_HI: rd_next = cmpa_reg[15:8];
      DBGTT_REG_CMPA_LO: rd_next = cmpa_reg[7:0];
      DBGTT_REG_CMPB_HI: rd_next = cmpb_reg[15:8];
      DBGTT_REG_CMPB_LO: rd_next = cmpb_reg[7:0];
      DBGTT_REG_FIFO_HI: rd_next = is_event ? 8'h00 : fifo_reg[DBGTT_DEPTH-1][15:8];
      DBGTT_REG_FIFO_LO: rd_next = fifo_reg[DBGTT_DEPTH-1][7:0];
      DBGTT_REG_CTRL: begin
        rd_next = ctrl_reg;
        rd_next[DBGTT_CTRL_ARM] = armed;
      end
      DBGTT_REG_TRIG: rd_next = trig_reg;
      DBGTT_REG_STAT: begin
        rd_next[DBGTT_STAT_RUN_ARMED_FLAG] = armed;
        rd_next[DBGTT_STAT_AF] = af_reg;
        rd_next[DBGTT_STAT_BF] = bf_reg;
        rd_next[DBGTT_STAT_CNT_LSB +: 4] = cnt_reg;
      end
      default: rd_next = 8'h00;
    endcase
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= DBGTT_RST_BYTE;
    end else if (REG_RD_I) begin
      rdata_reg <= rd_next;
    end
  end
  assign REG_RDATA_O = rdata_reg;

  property p_arm_start;
    @(posedge CLK_I) disable iff (RST_I) start_run |=> armed && cnt_reg == 4'h0;
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("arm write did not start clean run");

  property p_stop;
    @(posedge CLK_I) disable iff (RST_I) stop_run |=> !armed && !BRK_TAG_O;
  endproperty
  a_stop: assert property (p_stop) else $error("disarm write did not stop run");

  property p_begin_full;
    @(posedge CLK_I) disable iff (RST_I)
      (st_reg == DBGTT_ST_STORE && store && cnt_reg == 4'h7 && !REG_WR_I) |=> !armed;
  endproperty
  a_begin_full: assert property (p_begin_full) else $error("begin run kept going when full");

  property p_bdc_quiet;
    @(posedge CLK_I) disable iff (RST_I) CPU_BUS_I.bdc |-> chan_raw == 2'b00;
  endproperty
  a_bdc_quiet: assert property (p_bdc_quiet) else $error("match during background access");

  property p_force;
    @(posedge CLK_I) disable iff (RST_I)
      (brk_en && !ctrl_reg[DBGTT_CTRL_TAG] && trig) |=>
        BRK_FORCE_O ##1 (BRK_FORCE_O || $past(CPU_BRK_ACK_I));
  endproperty
  a_force: assert property (p_force) else $error("force request dropped before ack");

  property p_skip;
    @(posedge CLK_I) disable iff (RST_I)
      (st_reg == DBGTT_ST_PRE && st_next == DBGTT_ST_STORE && !REG_WR_I) |=>
        !store ##1 (skip_reg < 2'h2 || !$past(CPU_BUS_I.valid));
  endproperty
  a_skip: assert property (p_skip) else $error("flow stored inside blanking window");

  property p_profile;
    @(posedge CLK_I) disable iff (RST_I)
      (prof_push && !REG_WR_I) |=> fifo_reg[0] == $past(last_fetch_reg) && !armed;
  endproperty
  a_profile: assert property (p_profile) else $error("profiling read did not push fetch address");

  property p_read_shift;
    @(posedge CLK_I) disable iff (RST_I)
      rd_lo |=> fifo_reg[DBGTT_DEPTH-1] == $past(fifo_reg[DBGTT_DEPTH-2]);
  endproperty
  a_read_shift: assert property (p_read_shift) else $error("low byte read did not shift");

endmodule : dbgtt_top
`default_nettype wire

//--- dv/dbgtt_cpu_model.sv
// CPU core model for the debug unit: bus cycles, flow reports, queue events, break acks.
// Assumes the bench calls its tasks from one process on the shared bus clock.
`timescale 1ns/10ps
`default_nettype none
module dbgtt_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic brk_tag_i,
  input wire logic brk_force_i,
  output var dbgtt_pkg::dbgtt_bus_t bus_o,
  output var dbgtt_pkg::dbgtt_cof_t cof_o,
  output logic exec_o,
  output logic flush_o,
  output logic ack_o
);
  import dbgtt_pkg::*;
  logic [3:0] wait_cnt;
  logic tag_seen;
  initial begin
    bus_o = '0;
    cof_o = '0;
    exec_o = 1'b0;
    flush_o = 1'b0;
    tag_seen = 1'b0;
  end
  // Break taken at any cycle, ack_dly_i cycles late; no instruction boundary is checked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      if (brk_force_i && !ack_o && wait_cnt == ack_dly_i) begin
        ack_o <= 1'b1;
        wait_cnt <= 4'h0;
      end else if (brk_force_i && !ack_o) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
  // Idle bus shows inverted values, so a stale address can never look valid
  task automatic cyc(input dbgtt_bus_t b, input dbgtt_cof_t c);
    @(posedge clk_i);
    bus_o <= b;
    cof_o <= c;
    @(negedge clk_i);
    tag_seen = brk_tag_i;
    @(posedge clk_i);
    bus_o <= {1'b0, ~b[$bits(dbgtt_bus_t)-2:0]};
    cof_o <= {1'b0, ~c[$bits(dbgtt_cof_t)-2:0]};
  endtask : cyc
  task automatic qev(input logic ex, input logic fl);
    @(posedge clk_i);
    exec_o <= ex;
    flush_o <= fl;
    @(posedge clk_i);
    exec_o <= 1'b0;
    flush_o <= 1'b0;
  endtask : qev
endmodule : dbgtt_cpu_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the debug trigger and trace unit; plays the host debugger.
// Assumes register port and CPU model share one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dbgtt_pkg::*;
  localparam logic [15:0] ADR_A = 16'h1000;
  localparam logic [15:0] ADR_B = 16'h10ff;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] ack_dly = 4'h0;
  logic exec, flush, ack, brk_tag, brk_force;
  dbgtt_bus_t bus;
  dbgtt_cof_t cof;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  dbgtt_top uut (
    .CLK_I(clk), .RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .CPU_BUS_I(bus),
    .CPU_COF_I(cof), .CPU_OP_EXEC_I(exec), .CPU_Q_FLUSH_I(flush), .CPU_BRK_ACK_I(ack),
    .BRK_TAG_O(brk_tag), .BRK_FORCE_O(brk_force)
  );
  dbgtt_cpu_model cpu (
    .clk_i(clk), .rst_i(rst), .ack_dly_i(ack_dly), .brk_tag_i(brk_tag),
    .brk_force_i(brk_force), .bus_o(bus), .cof_o(cof), .exec_o(exec), .flush_o(flush),
    .ack_o(ack)
  );
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // The whole run takes well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    cmp_count++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic want);
    cmp_count++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk1
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(d, e);
  endtask : rdchk
  task automatic setcmp(input logic [15:0] a, input logic [15:0] b);
    wr(DBGTT_REG_CMPA_HI, a[15:8]);
    wr(DBGTT_REG_CMPA_LO, a[7:0]);
    wr(DBGTT_REG_CMPB_HI, b[15:8]);
    wr(DBGTT_REG_CMPB_LO, b[7:0]);
  endtask : setcmp
  task automatic arm(input logic [7:0] tg, input logic [7:0] ct);
    wr(DBGTT_REG_TRIG, tg);
    wr(DBGTT_REG_CTRL, ct);
  endtask : arm
  // f is {read, opcode fetch, background access}
  function automatic dbgtt_bus_t mk(input logic [15:0] a, input logic [2:0] f,
                                    input logic [7:0] w, input logic [7:0] r);
    mk = {1'b1, f, a, w, r};
  endfunction : mk
  // Only the field that the kind selects carries x
  function automatic dbgtt_cof_t mc(input logic [1:0] k, input logic [15:0] x);
    mc = {1'b1, k, (k == 2'h0) ? x : ~x, (k == 2'h3) ? x : ~x, (k == 2'h2) ? x : ~x};
  endfunction : mc
  task automatic t_reset();
    chk1(brk_force, 1'b0);
    chk1(brk_tag, 1'b0);
    rdchk(DBGTT_REG_STAT, 8'h00);
    rdchk(4'h9, 8'h00);
  endtask : t_reset
  task automatic t_flags();
    setcmp(ADR_A, ADR_B);
    arm(8'h40, 8'hc4);
    cpu.cyc(mk(ADR_A, 3'b001, 8'h00, 8'h00), '0);
    rdchk(DBGTT_REG_STAT, 8'h80);
    cpu.cyc(mk(ADR_A, 3'b100, 8'h00, 8'h00), '0);
    rdchk(DBGTT_REG_STAT, 8'h80);
    cpu.cyc(mk(ADR_A, 3'b000, 8'h00, 8'h00), '0);
    rdchk(DBGTT_REG_STAT, 8'hc0);
    wr(DBGTT_REG_CTRL, 8'h80);
    rdchk(DBGTT_REG_STAT, 8'h40);
    arm(8'h40, 8'hc0);
    rdchk(DBGTT_REG_STAT, 8'h80);
  endtask : t_flags
  task automatic t_trace();
    logic [15:0] exp_q[$];
    logic [7:0] hi, lo;
    logic [15:0] x;
    cpu.cyc(mk(ADR_A, 3'b100, 8'h00, 8'h00), mc(2'h0, 16'h0aaa));
    cpu.cyc(mk(16'h2000, 3'b100, 8'h00, 8'h00), mc(2'h2, 16'h0bbb));
    cpu.cyc(mk(16'h2001, 3'b100, 8'h00, 8'h00), mc(2'h3, 16'h0ccc));
    for (int i = 0; i < 11; i++) begin
      x = 16'h3000 + 16'h0111 * 16'(i);
      if (i % 4 != 1) exp_q.push_back(x);
      cpu.cyc(mk(16'h2002, 3'b100, 8'h00, 8'h00), mc(2'(i % 4), x));
    end
    rdchk(DBGTT_REG_STAT, 8'h48);
    cpu.cyc(mk(16'h4321, 3'b110, 8'h00, 8'h00), '0);
    for (int i = 0; i < 16; i++) begin
      x = (i < 8) ? exp_q[i] : 16'h4321;
      rd(DBGTT_REG_FIFO_HI, hi);
      rd(DBGTT_REG_FIFO_LO, lo);
      chk8(hi, x[15:8]);
      chk8(lo, x[7:0]);
    end
  endtask : t_trace
  task automatic t_event();
    logic [7:0] s;
    setcmp(ADR_A, 16'h1234);
    arm(8'h03, 8'hc0);
    for (int i = 0; i < 8; i++)
      cpu.cyc(mk(16'h1234, 3'b100, 8'hff, 8'h05 + 8'h1b * 8'(i)), '0);
    rdchk(DBGTT_REG_STAT, 8'h28);
    for (int i = 0; i < 8; i++) begin
      rdchk(DBGTT_REG_FIFO_HI, 8'h00);
      rdchk(DBGTT_REG_FIFO_LO, 8'h05 + 8'h1b * 8'(i));
    end
    arm(8'h04, 8'hc0);
    cpu.cyc(mk(16'h1234, 3'b100, 8'hff, 8'h5e), '0);
    cpu.cyc(mk(ADR_A, 3'b100, 8'hff, 8'h5e), '0);
    cpu.cyc(mk(16'h1234, 3'b100, 8'hff, 8'h5e), '0);
    rd(DBGTT_REG_STAT, s);
    chk8(s & 8'h0f, 8'h01);
  endtask : t_event
  task automatic brk_try(input logic [7:0] tg, input logic [7:0] ct, input dbgtt_bus_t b,
                         input logic e);
    logic seen;
    seen = 1'b0;
    arm(tg, ct);
    cpu.cyc(b, '0);
    repeat (3) begin
      @(posedge clk);
      #1 seen = seen | brk_force;
    end
    chk1(seen, e);
    if (e && ack_dly > 4'h3) chk1(brk_force, 1'b1);
    for (int k = 0; k < 20 && brk_force !== 1'b0; k++) @(posedge clk);
    #1 chk1(brk_force, 1'b0);
  endtask : brk_try
  task automatic t_breaks();
    // Entries are {mode, expected break, address}
    logic [23:0] tbl[11] = '{24'h011000, 24'h001001, 24'h1110ff, 24'h2010ff, 24'h700fff,
      24'h711000, 24'h7110ff, 24'h701100, 24'h801080, 24'h810fff, 24'h811100};
    setcmp(ADR_A, ADR_B);
    for (int i = 0; i < 11; i++) begin
      ack_dly <= 4'h5 * 4'(i % 2);
      brk_try({4'h0, tbl[i][23:20]}, 8'hd0, mk(tbl[i][15:0], 3'b100, 8'h00, 8'h00),
              tbl[i][16]);
    end
    setcmp(ADR_A, 16'h0077);
    brk_try(8'h05, 8'hd4, mk(ADR_A, 3'b000, 8'h00, 8'h77), 1'b0);
    brk_try(8'h05, 8'hd4, mk(ADR_A, 3'b000, 8'h77, 8'h00), 1'b1);
    brk_try(8'h06, 8'hd0, mk(ADR_A, 3'b100, 8'h00, 8'h77), 1'b0);
    brk_try(8'h06, 8'hd0, mk(ADR_A, 3'b100, 8'h77, 8'h78), 1'b1);
  endtask : t_breaks
  task automatic t_tag();
    logic [7:0] s;
    arm(8'h80, 8'hf0);
    cpu.cyc(mk(ADR_A, 3'b110, 8'h00, 8'h00), '0);
    chk1(cpu.tag_seen, 1'b1);
    cpu.qev(1'b0, 1'b1);
    cpu.cyc(mk(16'h1002, 3'b110, 8'h00, 8'h00), '0);
    chk1(cpu.tag_seen, 1'b0);
    cpu.cyc(mk(ADR_A, 3'b110, 8'h00, 8'h00), '0);
    cpu.qev(1'b1, 1'b0);
    rd(DBGTT_REG_STAT, s);
    chk8(s & 8'h80, 8'h80);
    cpu.qev(1'b1, 1'b0);
    rd(DBGTT_REG_STAT, s);
    chk8(s & 8'h80, 8'h00);
    chk1(brk_force, 1'b0);
  endtask : t_tag
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_trace();
    t_event();
    t_breaks();
    t_tag();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
